// [rtl/monitor_defs.svh]
`ifndef MONITOR_DEFS_SVH
`define MONITOR_DEFS_SVH
`define CLK_HZ 100000000
`define FRAME_MS 30
`define NUM_CH 5
`define OFF_CTRL 10'h000
`define OFF_RES_FIRST 10'h004
`define OFF_RES_LAST 10'h014
`define OFF_ALARM 10'h018
`define OFF_WARN 10'h01c
`define OFF_ISTAT 10'h020
`define OFF_IMASK 10'h024
`define OFF_PINS 10'h028
`define OFF_LIM_FIRST 10'h040
`define OFF_LIM_LAST 10'h08c
`define OFF_LUT_FIRST 10'h200
`define OFF_LUT_LAST 10'h31c
`define CTRL_RESET 3'h1
`define TEMP_RAW_MAX 18'sh07ffc
`define TEMP_RAW_MIN 18'sh38000
`define UNS_RAW_MAX 18'sh0fff8
`define TEMP_CODE_MAX 16'h7ffc
`define TEMP_CODE_MIN 16'h8000
`define UNS_CODE_MAX 16'hfff8
`define UNS_CODE_MIN 16'h0000
`define LUT_LOW_DEG 8'hd8
`define LUT_HIGH_DEG 8'h66
`define LUT_OFFSET_DEG 9'h028
`define LUT_LAST_IDX 7'h47
`define DEV_ADDR 7'h51
`define BYTE_RES_END 4'ha
`define BYTE_ALARM_HI 4'ha
`define BYTE_ALARM_LO 4'hb
`define BYTE_WARN_HI 4'hc
`define BYTE_WARN_LO 4'hd
`endif

// [rtl/monitor_pkg.sv]
package monitor_pkg;
   typedef enum logic [2:0] {
      CH_TEMP, CH_VCC, CH_EXT_INPUT_A, CH_EXT_INPUT_B, CH_EXT_INPUT_C
   } chan_t;
   typedef enum logic {C_IDLE, C_BUSY} conv_state_t;
   typedef enum logic [2:0] {
      I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD, I_RACK
   } serial_state_t;
   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic run;
      logic lsb_mask;
      logic lim_out_en;
      logic [19:0][15:0] lim;
      logic [71:0][15:0] lut;
      logic [15:0] pos;
      logic [4:0][15:0] res;
      logic [9:0] alarm;
      logic [9:0] warn;
      logic [9:0] istat;
      logic [9:0] imask;
      logic irq;
      logic [31:0] slot;
      chan_t chan;
      conv_state_t cst;
      logic conv_req;
      logic oe_a;
      logic oe_b;
      serial_state_t ist;
      logic [3:0] bits;
      logic [7:0] sh;
      logic [7:0] tx;
      logic [7:0] hold;
      logic [3:0] ptr;
      logic rw;
      logic sda_oe;
   } state_t;
endpackage

// [rtl/link_sampler.sv]
`timescale 1ns/100ps
`default_nettype none
module link_sampler #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;
   logic [W-1:0] prev_ff;
   // Only sync_ff reads meta_ff; edges come from the settled copies
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_ff <= '0;
         sync_ff <= '0;
         prev_ff <= '0;
      end else begin
         meta_ff <= d;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end
   assign q = sync_ff;
   assign rise = sync_ff & ~prev_ff;
   assign fall = ~sync_ff & prev_ff;
endmodule
`default_nettype wire

// [rtl/limit_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module limit_checker (
   input wire logic [15:0] value,
   input wire logic is_signed,
   input wire logic [15:0] alarm_hi_lim,
   input wire logic [15:0] alarm_lo_lim,
   input wire logic [15:0] warn_hi_lim,
   input wire logic [15:0] warn_lo_lim,
   output logic alarm_hi,
   output logic alarm_lo,
   output logic warn_hi,
   output logic warn_lo
);
   logic [15:0] v;
   logic [15:0] ah;
   logic [15:0] al;
   logic [15:0] wh;
   logic [15:0] wl;
   // Sign flip maps two's complement order onto unsigned order
   assign v = {value[15] ^ is_signed, value[14:0]};
   assign ah = {alarm_hi_lim[15] ^ is_signed, alarm_hi_lim[14:0]};
   assign al = {alarm_lo_lim[15] ^ is_signed, alarm_lo_lim[14:0]};
   assign wh = {warn_hi_lim[15] ^ is_signed, warn_hi_lim[14:0]};
   assign wl = {warn_lo_lim[15] ^ is_signed, warn_lo_lim[14:0]};
   assign alarm_hi = v > ah;
   assign alarm_lo = v < al;
   assign warn_hi = v > wh;
   assign warn_lo = v < wl;
endmodule
`default_nettype wire

// [rtl/monitor_channel_readout.sv]
`timescale 1ns/100ps
`default_nettype none
`include "monitor_defs.svh"
// Summary of operation
// - Results are left-justified 16-bit words
// - Trim variant zeroes three low bits
// - Channels refreshed in repeating rotation
// - Per-channel done bit after conversion
// - Automatic limit compare sets flags
// - Separate alarm and warning flags
// - Per-channel maskable limit interrupt
// - Optional first output on alarm
// - Each logic input drives its output
// - Temperature signed, others unsigned
// - Codes saturate at full-scale values
// - Fixed code step per channel
// - Two positions per 2-degree step
// - Temperature high byte whole degrees
// - Each channel refreshed within frame
// - Alarm and warning flags separate bytes
module monitor_channel_readout #(
   parameter int SLOT_CYCLES = `FRAME_MS * (`CLK_HZ / 1000) / `NUM_CH
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output monitor_pkg::chan_t conv_chan,
   output logic conv_req,
   input wire logic conv_valid,
   input wire logic signed [17:0] conv_raw,
   output logic [7:0] resistor_pos_0,
   output logic [7:0] resistor_pos_1,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic buffer_in_a,
   input wire logic buffer_in_b,
   input wire logic open_drain_out_a_i,
   output logic open_drain_out_a_o,
   output logic open_drain_out_a_oe,
   input wire logic open_drain_out_b_i,
   output logic open_drain_out_b_o,
   output logic open_drain_out_b_oe
);
   import monitor_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   state_t r;
   state_t n;
   logic [5:0] pin_q;
   logic [5:0] pin_rise;
   logic [5:0] pin_fall;
   logic [15:0] sat_val;
   logic [3:0][15:0] cur_lim;
   logic al_hi;
   logic al_lo;
   logic wn_hi;
   logic wn_lo;
   logic start_seen;
   logic stop_seen;

   function automatic logic [15:0] saturate(
      input logic signed [17:0] raw,
      input logic is_temp,
      input logic trim
   );
      logic [15:0] v;
      v = raw[15:0];
      if (is_temp) begin
         if (raw > `TEMP_RAW_MAX) v = `TEMP_CODE_MAX;
         if (raw < `TEMP_RAW_MIN) v = `TEMP_CODE_MIN;
      end else begin
         if (raw > `UNS_RAW_MAX) v = `UNS_CODE_MAX;
         if (raw < 18'sh00000) v = `UNS_CODE_MIN;
      end
      if (trim) v[2:0] = 3'h0;
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   link_sampler #(.W(6)) u_pins (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .d({open_drain_out_b_i, open_drain_out_a_i, buffer_in_b, buffer_in_a, sda_i, scl_i}),
      .q(pin_q),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   assign start_seen = pin_fall[1] & pin_q[0];
   assign stop_seen = pin_rise[1] & pin_q[0];

   // Converter delivers whole.fraction two's complement for temperature
   assign sat_val = saturate(conv_raw, r.chan == CH_TEMP, r.lsb_mask);
   assign cur_lim = r.lim[{r.chan, 2'b00} +: 4];

   limit_checker u_check (
      .value(sat_val),
      .is_signed(r.chan == CH_TEMP),
      .alarm_hi_lim(cur_lim[0]),
      .alarm_lo_lim(cur_lim[1]),
      .warn_hi_lim(cur_lim[2]),
      .warn_lo_lim(cur_lim[3]),
      .alarm_hi(al_hi),
      .alarm_lo(al_lo),
      .warn_hi(wn_hi),
      .warn_lo(wn_lo)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic acc;
      logic [9:0] w1c;
      logic [4:0] ev_done;
      logic [4:0] ev_lim;
      logic [31:0] rd;
      logic hit;
      logic [2:0] ri;
      logic [4:0] li;
      logic [6:0] ui;
      logic [3:0] ci;
      logic [3:0] lp;
      logic [7:0] fb;
      logic [7:0] fh;
      logic signed [8:0] ts;
      logic [6:0] ti;
      acc = psel & penable & r.pready;
      w1c = 10'h000;
      ev_done = 5'h00;
      ev_lim = 5'h00;
      rd = 32'h0000_0000;
      hit = 1'b1;
      ri = 3'((paddr - `OFF_RES_FIRST) >> 2);
      li = 5'((paddr - `OFF_LIM_FIRST) >> 2);
      ui = 7'((paddr - `OFF_LUT_FIRST) >> 2);
      ci = {r.chan, 1'b0};
      lp = (r.ist == I_RACK) ? r.ptr + 4'h1 : r.ptr;
      fb = 8'h00;
      fh = 8'h00;
      ts = 9'sh000;
      ti = 7'h00;
      n = r;
      n.conv_req = 1'b0;

      // Register read decode
      if (paddr[1:0] != 2'h0) begin
         hit = 1'b0;
      end else if (paddr == `OFF_CTRL) begin
         rd = {29'h0, r.lim_out_en, r.lsb_mask, r.run};
      end else if (paddr >= `OFF_RES_FIRST && paddr <= `OFF_RES_LAST) begin
         rd = {16'h0000, r.res[ri]};
      end else if (paddr == `OFF_ALARM) begin
         rd = {22'h0, r.alarm};
      end else if (paddr == `OFF_WARN) begin
         rd = {22'h0, r.warn};
      end else if (paddr == `OFF_ISTAT) begin
         rd = {22'h0, r.istat};
      end else if (paddr == `OFF_IMASK) begin
         rd = {22'h0, r.imask};
      end else if (paddr == `OFF_PINS) begin
         rd = {25'h0, r.chan, pin_q[5:2]};
      end else if (paddr >= `OFF_LIM_FIRST && paddr <= `OFF_LIM_LAST) begin
         rd = {16'h0000, r.lim[li]};
      end else if (paddr >= `OFF_LUT_FIRST && paddr <= `OFF_LUT_LAST) begin
         rd = {16'h0000, r.lut[ui]};
      end else begin
         hit = 1'b0;
      end

      // No wait state: answer built in setup, pready in first access cycle
      n.pready = psel & ~penable;
      if (psel && !penable) begin
         n.prdata = hit ? rd : 32'h0000_0000;
         n.pslverr = ~hit;
      end
      if (acc && pwrite && hit) begin
         if (paddr == `OFF_CTRL) begin
            {n.lim_out_en, n.lsb_mask, n.run} = pwdata[2:0];
         end else if (paddr == `OFF_ISTAT) begin
            w1c = pwdata[9:0];
         end else if (paddr == `OFF_IMASK) begin
            n.imask = pwdata[9:0];
         end else if (paddr >= `OFF_LIM_FIRST && paddr <= `OFF_LIM_LAST) begin
            n.lim[li] = pwdata[15:0];
         end else if (paddr >= `OFF_LUT_FIRST && paddr <= `OFF_LUT_LAST) begin
            n.lut[ui] = pwdata[15:0];
         end
      end

      // Slot timer keeps a fixed pace even while a conversion is out
      if (r.slot == 32'(SLOT_CYCLES - 1)) begin
         n.slot = 32'h0000_0000;
         if (r.run && r.cst == C_IDLE) begin
            n.conv_req = 1'b1;
            n.cst = C_BUSY;
         end
      end else begin
         n.slot = r.slot + 32'h1;
      end

      if (r.cst == C_BUSY && conv_valid) begin
         // Whole word stored in one edge; code passed unscaled
         n.res[r.chan] = sat_val;
         n.alarm[ci +: 2] = {al_lo, al_hi};
         n.warn[ci +: 2] = {wn_lo, wn_hi};
         ev_done[r.chan] = 1'b1;
         ev_lim[r.chan] = al_lo | al_hi | wn_lo | wn_hi;
         n.cst = C_IDLE;
         if (r.chan == CH_EXT_INPUT_C) begin
            n.chan = CH_TEMP;
         end else begin
            n.chan = chan_t'(3'(r.chan + 3'h1));
         end
      end

      // Sticky flags: a new event beats a same-cycle clear
      n.istat = (r.istat & ~w1c) | {ev_done, ev_lim};
      n.irq = |(n.istat & n.imask);

      // Temperature to table row, clamped at both ends
      if ($signed(r.res[CH_TEMP][15:8]) < $signed(`LUT_LOW_DEG)) begin
         ti = 7'h00;
      end else if ($signed(r.res[CH_TEMP][15:8]) > $signed(`LUT_HIGH_DEG)) begin
         ti = `LUT_LAST_IDX;
      end else begin
         ts = $signed({r.res[CH_TEMP][15], r.res[CH_TEMP][15:8]}) + $signed(`LUT_OFFSET_DEG);
         ti = ts[7:1];
      end
      n.pos = r.lut[ti];

      // Output released (high) on alarm when enabled
      n.oe_a = ~pin_q[2] & ~(r.lim_out_en & |r.alarm);
      n.oe_b = ~pin_q[3];

      // Serial readout byte fetch
      if (lp < `BYTE_RES_END) begin
         if (!lp[0]) begin
            fb = r.res[lp[3:1]][15:8];
            fh = r.res[lp[3:1]][7:0];
         end else begin
            fb = r.hold;
         end
      end else if (lp == `BYTE_ALARM_HI) begin
         fb = {6'h00, r.alarm[9:8]};
      end else if (lp == `BYTE_ALARM_LO) begin
         fb = r.alarm[7:0];
      end else if (lp == `BYTE_WARN_HI) begin
         fb = {6'h00, r.warn[9:8]};
      end else if (lp == `BYTE_WARN_LO) begin
         fb = r.warn[7:0];
      end

      // Serial slave: no clock stretching, pointer then sequential reads
      if (stop_seen) begin
         n.ist = I_IDLE;
         n.sda_oe = 1'b0;
      end else if (start_seen) begin
         n.ist = I_ADDR;
         n.bits = 4'h0;
         n.sda_oe = 1'b0;
      end else if (pin_rise[0]) begin
         unique case (r.ist)
            I_ADDR, I_WR: begin
               n.sh = {r.sh[6:0], pin_q[1]};
               n.bits = r.bits + 4'h1;
            end
            I_RD: n.bits = r.bits + 4'h1;
            I_RACK: begin
               if (pin_q[1]) n.ist = I_IDLE;
            end
            I_IDLE, I_AACK, I_WACK: ;
         endcase
      end else if (pin_fall[0]) begin
         unique case (r.ist)
            I_ADDR: begin
               if (r.bits == 4'h8) begin
                  if (r.sh[7:1] == `DEV_ADDR) begin
                     n.ist = I_AACK;
                     n.sda_oe = 1'b1;
                     n.rw = r.sh[0];
                  end else begin
                     n.ist = I_IDLE;
                  end
               end
            end
            I_WR: begin
               if (r.bits == 4'h8) begin
                  n.ptr = r.sh[3:0];
                  n.ist = I_WACK;
                  n.sda_oe = 1'b1;
               end
            end
            I_AACK, I_WACK, I_RACK: begin
               n.bits = 4'h0;
               if (r.rw) begin
                  n.ptr = lp;
                  n.tx = fb;
                  n.sda_oe = ~fb[7];
                  n.ist = I_RD;
                  // MSB read snapshots the low byte for atomic pairing
                  if (lp < `BYTE_RES_END && !lp[0]) n.hold = fh;
               end else begin
                  n.ist = I_WR;
                  n.sda_oe = 1'b0;
               end
            end
            I_RD: begin
               if (r.bits == 4'h8) begin
                  n.ist = I_RACK;
                  n.sda_oe = 1'b0;
               end else begin
                  n.tx = {r.tx[6:0], 1'b0};
                  n.sda_oe = ~r.tx[6];
               end
            end
            I_IDLE: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
         {r.lim_out_en, r.lsb_mask, r.run} <= `CTRL_RESET;
      end else begin
         r <= n;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign irq = r.irq;
   assign conv_chan = r.chan;
   assign conv_req = r.conv_req;
   assign resistor_pos_0 = r.pos[7:0];
   assign resistor_pos_1 = r.pos[15:8];
   assign sda_o = 1'b0;
   assign sda_oe = r.sda_oe;
   assign open_drain_out_a_o = 1'b0;
   assign open_drain_out_a_oe = r.oe_a;
   assign open_drain_out_b_o = 1'b0;
   assign open_drain_out_b_oe = r.oe_b;
endmodule
`default_nettype wire

// [testbench/monitor_checker_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module monitor_checker (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire monitor_pkg::chan_t conv_chan,
   input wire logic conv_req,
   input wire logic conv_valid,
   input wire logic buffer_in_a,
   input wire logic buffer_in_b,
   input wire logic open_drain_out_a_oe,
   input wire logic open_drain_out_b_oe
);
   import monitor_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////
   a_setup_answer: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("error read returned data");
   a_misalign_err: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
      else $error("misaligned access not refused");
   a_req_spaced: assert property (conv_req |=> !conv_req [*8])
      else $error("conversion requests too close");
   a_chan_held: assert property (!conv_valid |=> $stable(conv_chan))
      else $error("channel moved without a result");
   a_chan_next: assert property (conv_valid |=> 3'(conv_chan) ==
      (($past(conv_chan) == CH_EXT_INPUT_C) ? 3'h0 : 3'($past(conv_chan)) + 3'h1))
      else $error("rotation order broken");
   a_buf_a_off: assert property (buffer_in_a [*6] |-> !open_drain_out_a_oe)
      else $error("first output pulled with input high");
   a_buf_b_off: assert property (buffer_in_b [*6] |-> !open_drain_out_b_oe)
      else $error("second output pulled with input high");
   a_buf_b_on: assert property (!buffer_in_b [*6] |-> open_drain_out_b_oe)
      else $error("second output released with input low");
endmodule
bind monitor_channel_readout monitor_checker chk_i (.*);
`default_nettype wire

// [testbench/conv_model.sv]
`timescale 1ns/100ps
`default_nettype none
module conv_model (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic conv_req,
   input wire monitor_pkg::chan_t conv_chan,
   output logic conv_valid,
   output logic signed [17:0] conv_raw
);
   import monitor_pkg::*;
   logic busy;
   logic slow;
   logic [3:0] wait_cnt;
   // Beyond full scale on three channels to force clamping
   function automatic logic signed [17:0] code_of(input chan_t c);
      case (c)
         CH_TEMP: return 18'sh08000;
         CH_VCC: return 18'sh1ffff;
         CH_EXT_INPUT_A: return 18'sh3ffff;
         CH_EXT_INPUT_B: return 18'sh01237;
         default: return 18'sh00abc;
      endcase
   endfunction
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy <= 1'b0;
         slow <= 1'b0;
         wait_cnt <= 4'h0;
         conv_valid <= 1'b0;
         conv_raw <= 18'sh2aaaa;
      end else begin
         conv_valid <= 1'b0;
         // Data not held outside the valid cycle
         conv_raw <= ~conv_raw;
         if (conv_req) begin
            busy <= 1'b1;
            wait_cnt <= slow ? 4'h7 : 4'h0;
            slow <= ~slow;
         end else if (busy && wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
         end else if (busy) begin
            busy <= 1'b0;
            conv_valid <= 1'b1;
            conv_raw <= code_of(conv_chan);
         end
      end
   end
endmodule
`default_nettype wire

// [testbench/monitor_channel_readout_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "monitor_defs.svh"
module monitor_channel_readout_tb;
   import monitor_pkg::*;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, irq, conv_req, conv_valid, sda_o, sda_oe;
   logic oe_a, oe_b, out_a_o, out_b_o, e;
   chan_t conv_chan;
   logic signed [17:0] conv_raw;
   logic [7:0] pos0, pos1;
   logic scl = 1'b1;
   logic sda_m = 1'b1;
   logic in_a = 1'b0;
   logic in_b = 1'b0;
   logic [31:0] q;
   logic [7:0] sb;
   logic ack;
   int failures = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [15:0] exp_res [5] = '{16'h7ffc, 16'hfff8, 16'h0000, 16'h1237, 16'h0abc};
   monitor_channel_readout #(.SLOT_CYCLES(50)) uut (.core_clk(core_clk), .arst_n(arst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .conv_chan(conv_chan), .conv_req(conv_req), .conv_valid(conv_valid),
      .conv_raw(conv_raw), .resistor_pos_0(pos0), .resistor_pos_1(pos1),
      .scl_i(scl), .sda_i(sda_m & ~sda_oe), .sda_o(sda_o), .sda_oe(sda_oe),
      .buffer_in_a(in_a), .buffer_in_b(in_b), .open_drain_out_a_i(~oe_a),
      .open_drain_out_a_o(out_a_o), .open_drain_out_a_oe(oe_a),
      .open_drain_out_b_i(~oe_b), .open_drain_out_b_o(out_b_o),
      .open_drain_out_b_oe(oe_b));
   conv_model conv_i (.core_clk(core_clk), .arst_n(arst_n), .conv_req(conv_req),
      .conv_chan(conv_chan), .conv_valid(conv_valid), .conv_raw(conv_raw));
   ////////////////////////////////////////////////////////////////
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         print_verdict();
      end
   end
   task automatic print_verdict;
      if (failures == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Request held until ready seen high at a rising edge
   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic wait_done;
      int n;
      n = 0;
      do begin
         apb(1'b0, `OFF_ISTAT, 32'h0);
         n++;
      end while (q[9:5] !== 5'h1f && n < 300);
      chk(32'(q[9:5]), 32'h1f);
   endtask
   // Serial clock stands high between frames; line read mid-high
   task automatic sbit(input logic b, output logic got);
      idle(4);
      sda_m <= b;
      idle(4);
      scl <= 1'b1;
      idle(4);
      got = sda_m & ~sda_oe;
      idle(4);
      scl <= 1'b0;
   endtask
   // Eight bits MSB first, then the acknowledge slot
   task automatic sbyte(input logic [7:0] d, input logic a, output logic [7:0] got,
      output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         sbit(d[i], b);
         got[i] = b;
      end
      sbit(a, ack);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      idle(4);
      arst_n <= 1'b1;
      rd(`OFF_CTRL, 32'h1);
      rd(`OFF_IMASK, 32'h0);
      rd(`OFF_LIM_FIRST, 32'h0);
      rd(10'h3fc, 32'h0);
      chk(e, 1'b1);
      rd(10'h002, 32'h0);
      chk(e, 1'b1);
      for (int c = 0; c < 5; c++) begin
         wr(10'(`OFF_LIM_FIRST + c * 16), (c == 0) ? 32'h7fff : 32'hffff);
         wr(10'(`OFF_LIM_FIRST + c * 16 + 8), (c == 0) ? 32'h7fff : 32'hffff);
      end
      // Signed compare flags this, unsigned would not
      wr(`OFF_LIM_FIRST, 32'h8000);
      wr(10'h070, 32'h1000);
      wr(10'h08c, 32'h1000);
      wr(`OFF_ISTAT, 32'h3ff);
      wait_done();
      for (int c = 0; c < 5; c++) rd(10'(`OFF_RES_FIRST + c * 4), exp_res[c]);
      chk(32'(q[15:4]), 32'h0ab);
      rd(`OFF_ALARM, 32'h041);
      rd(`OFF_WARN, 32'h200);
      apb(1'b0, `OFF_ISTAT, 32'h0);
      chk(q & 32'h1f, 32'h19);
      chk(irq, 1'b0);
      wr(`OFF_IMASK, 32'h8);
      idle(3);
      chk(irq, 1'b1);
      wr(`OFF_CTRL, 32'h0);
      idle(20);
      wr(`OFF_ISTAT, 32'h3ff);
      idle(3);
      chk(irq, 1'b0);
      rd(`OFF_ISTAT, 32'h0);
      wr(`OFF_LUT_LAST, 32'ha55a);
      idle(2);
      chk({pos1, pos0}, 32'ha55a);
      rd(`OFF_LUT_LAST, 32'ha55a);
      chk(oe_a, 1'b1);
      wr(`OFF_CTRL, 32'h4);
      idle(6);
      chk(oe_a, 1'b0);
      in_b <= 1'b1;
      idle(6);
      chk(oe_b, 1'b0);
      in_b <= 1'b0;
      in_a <= 1'b1;
      wr(`OFF_CTRL, 32'h0);
      idle(6);
      chk(oe_a, 1'b0);
      chk(oe_b, 1'b1);
      apb(1'b0, `OFF_PINS, 32'h0);
      chk(q & 32'hf, 32'h5);
      wr(`OFF_CTRL, 32'h3);
      wr(`OFF_ISTAT, 32'h3ff);
      wait_done();
      rd(`OFF_RES_FIRST + 10'h00c, 32'h1230);
      rd(`OFF_RES_FIRST + 10'h010, 32'h0ab8);
      // Pointer to the ext_b word, repeated start, MSB then LSB
      idle(4);
      sda_m <= 1'b0;
      idle(8);
      scl <= 1'b0;
      sbyte(8'ha2, 1'b1, sb, ack);
      chk(32'(ack), 32'h0);
      sbyte(8'h06, 1'b1, sb, ack);
      chk(32'(ack), 32'h0);
      idle(4);
      sda_m <= 1'b1;
      idle(4);
      scl <= 1'b1;
      idle(4);
      sda_m <= 1'b0;
      idle(8);
      scl <= 1'b0;
      sbyte(8'ha3, 1'b1, sb, ack);
      chk(32'(ack), 32'h0);
      sbyte(8'hff, 1'b0, sb, ack);
      chk(32'(sb), 32'h12);
      sbyte(8'hff, 1'b1, sb, ack);
      chk(32'(sb), 32'h30);
      idle(4);
      sda_m <= 1'b0;
      idle(4);
      scl <= 1'b1;
      idle(4);
      sda_m <= 1'b1;
      idle(8);
      chk(sda_oe, 1'b0);
      print_verdict();
   end
endmodule
`default_nettype wire
